// *** rxohs_map.vh ***
`ifndef RXOHS_MAP_VH
`define RXOHS_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define RXOHS_OFF_FW_REV 8'h61
`define RXOHS_OFF_DL_STAT 8'h62
`define RXOHS_OFF_BIT_CODE 8'h63
`define RXOHS_OFF_OH_WORD1 8'h64
`define RXOHS_OFF_OH_WORD2 8'h65
`define RXOHS_OFF_OH_WORD3 8'h66
`define RXOHS_OFF_MODE_CTRL 8'h70
`define RXOHS_OFF_RX_CTRL1 8'h71

// ****************************************
// Field positions
// ****************************************
`define RXOHS_MODE_E1_BIT 0
`define RXOHS_MODE_D4_BIT 1
`define RXOHS_CTRL1_CRC4_BIT 3
`define RXOHS_STAT_CRC4SRCH_BIT 2
`define RXOHS_STAT_CASSRCH_BIT 1
`define RXOHS_STAT_FASSRCH_BIT 0

// ****************************************
// Widths and reset values
// ****************************************
`define RXOHS_CNT_W 6
`define RXOHS_CNT_MAX 6'h3F
`define RXOHS_DL_W 8
`define RXOHS_CARRIER_W 24
`define RXOHS_BOC_W 6
`define RXOHS_RST_BYTE 8'h00
`define RXOHS_RST_MODE 8'h00
`define RXOHS_RST_CTRL1 8'h00

`endif

// *** rxohs_search_cnt.v ***
`timescale 1ns/1ps
// Saturating count of failed multiframe searches
module rxohs_search_cnt
(
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Events
	input wire search_expire,
	input wire mf_sync_ok,
	input wire crc4_enable,
	// Count
	output reg [5:0] count_ff
);
`include "rxohs_map.vh"

reg [5:0] nxt_count;

always @*
begin
	nxt_count = count_ff;
	if (mf_sync_ok || !crc4_enable)
	begin
		nxt_count = 6'h00;
	end
	else if (search_expire && (count_ff != `RXOHS_CNT_MAX))
	begin
		nxt_count = count_ff + 6'h01;
	end
end

always @(posedge clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		count_ff <= 6'h00;
	end
	else
	begin
		count_ff <= nxt_count;
	end
end

endmodule // rxohs_search_cnt

// *** rxohs_bit_collect.v ***
`timescale 1ns/1ps
// Gathers serial bits first-bit-at-LSB and publishes them as a word
module rxohs_bit_collect
#(
	parameter WIDTH = 8,
	parameter IDX_W = 3
)
(
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Serial bits
	input wire bit_in,
	input wire bit_vld,
	input wire boundary,
	input wire use_boundary,
	// Published word
	output reg [WIDTH-1:0] word_ff
);

reg [WIDTH-1:0] asm_ff;
reg [IDX_W-1:0] idx_ff;
reg [WIDTH-1:0] nxt_asm;
reg [IDX_W-1:0] nxt_idx;
reg [WIDTH-1:0] nxt_word;
wire last_bit;

assign last_bit = (idx_ff == WIDTH - 1);

always @*
begin
	nxt_asm = asm_ff;
	nxt_idx = idx_ff;
	nxt_word = word_ff;
	if (bit_vld)
	begin
		nxt_asm[idx_ff] = bit_in;
		nxt_idx = last_bit ? {IDX_W{1'b0}} : idx_ff + 1'b1;
	end
	// Boundary mode: unused upper bits read zero
	if (use_boundary && boundary)
	begin
		nxt_word = nxt_asm;
		nxt_asm = {WIDTH{1'b0}};
		nxt_idx = {IDX_W{1'b0}};
	end
	else if (!use_boundary && bit_vld && last_bit)
	begin
		nxt_word = nxt_asm;
		// Cleared so a later D4 word starts from zero
		nxt_asm = {WIDTH{1'b0}};
	end
end

always @(posedge clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		asm_ff <= {WIDTH{1'b0}};
		idx_ff <= {IDX_W{1'b0}};
		word_ff <= {WIDTH{1'b0}};
	end
	else
	begin
		asm_ff <= nxt_asm;
		idx_ff <= nxt_idx;
		word_ff <= nxt_word;
	end
end

endmodule // rxohs_bit_collect

// *** rxohs_regs.v ***
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module rxohs_regs
#(
	// Arbitrary neutral value
	parameter [7:0] FW_REVISION = 8'h01
)
(
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_ff,
	// Control toward framer
	output reg e1_mode_ff,
	output reg d4_mode_ff,
	output reg crc4_enable_ff,
	// E1 synchronizer state
	input wire crc4_mf_search_active,
	input wire cas_mf_search_active,
	input wire frame_align_search_active,
	input wire crc4_search_expire,
	input wire crc4_mf_sync_ok,
	// E1 timeslot zero
	input wire in_frame_align,
	input wire ts0_align_stb,
	input wire ts0_nonalign_stb,
	input wire [7:0] ts0_byte,
	input wire [3:0] mf_frame_num,
	// T1 data link
	input wire rx_facility_link_bit,
	input wire rx_facility_link_vld,
	input wire d4_mf_boundary,
	input wire rx_bit_code_vld,
	input wire [5:0] rx_bit_code_value,
	input wire carrier_bit,
	input wire carrier_bit_vld,
	input wire carrier_sf_boundary
);
`include "rxohs_map.vh"

// ****************************************
// Helpers
// ****************************************

// Picks the view of a shared offset
function [7:0] mode_view;
	input e1;
	input [7:0] t1_val;
	input [7:0] e1_val;
	begin
		mode_view = e1 ? e1_val : t1_val;
	end
endfunction

// Address match
function hit;
	input [7:0] addr;
	input [7:0] offset;
	begin
		hit = (addr == offset);
	end
endfunction

// ****************************************
// Declarations
// ****************************************
reg [7:0] rx_bit_code_last_ff;
reg [7:0] rx_align_frame_bits_ff;
reg [7:0] rx_nonalign_frame_bits_ff;
reg [7:0] rx_intl_bits_even_frames_ff;
reg [7:0] nxt_rdata;
reg [7:0] nxt_bit_code;
reg [7:0] nxt_align;
reg [7:0] nxt_nonalign;
reg [7:0] nxt_si_even;
reg nxt_e1_mode;
reg nxt_d4_mode;
reg nxt_crc4_enable;
wire [5:0] crc4_search_timeout_count;
wire [7:0] rx_facility_link_bits;
wire [23:0] carrier_word;
wire [7:0] rx_realtime_sync_status;
wire [7:0] mode_ctrl_view;
wire [7:0] rx_ctrl1_view;
wire [2:0] si_slot;
wire e1_capture_ok;
wire dl_vld_t1;
wire carrier_vld_t1;
localparam [7:0] MODE_RST = `RXOHS_RST_MODE;
localparam [7:0] CTRL1_RST = `RXOHS_RST_CTRL1;

// ****************************************
// CRC-4 search counter
// ****************************************
rxohs_search_cnt u_search_cnt
(
	.clk(clk),
	.reset_n(reset_n),
	.search_expire(crc4_search_expire & e1_mode_ff),
	.mf_sync_ok(crc4_mf_sync_ok),
	.crc4_enable(crc4_enable_ff),
	.count_ff(crc4_search_timeout_count)
);

// ****************************************
// Live E1 status
// ****************************************
// counter bit 1 dropped
// Skipping bit 1 stretches 5 bits past 400 ms at the cost of resolution
// no latching
assign rx_realtime_sync_status = {
	crc4_search_timeout_count[5:2],
	crc4_search_timeout_count[0],
	crc4_mf_search_active,
	cas_mf_search_active,
	frame_align_search_active
};

// ****************************************
// T1 data link assembly
// ****************************************
assign dl_vld_t1 = rx_facility_link_vld & ~e1_mode_ff;
assign carrier_vld_t1 = carrier_bit_vld & ~e1_mode_ff;

rxohs_bit_collect
#(
	.WIDTH(`RXOHS_DL_W),
	.IDX_W(3)
)
u_link_collect
(
	.clk(clk),
	.reset_n(reset_n),
	.bit_in(rx_facility_link_bit),
	.bit_vld(dl_vld_t1),
	.boundary(d4_mf_boundary & ~e1_mode_ff),
	.use_boundary(d4_mode_ff),
	.word_ff(rx_facility_link_bits)
);

rxohs_bit_collect
#(
	.WIDTH(`RXOHS_CARRIER_W),
	.IDX_W(5)
)
u_carrier_collect
(
	.clk(clk),
	.reset_n(reset_n),
	.bit_in(carrier_bit),
	.bit_vld(carrier_vld_t1),
	.boundary(carrier_sf_boundary & ~e1_mode_ff),
	.use_boundary(1'b1),
	.word_ff(carrier_word)
);

// ****************************************
// Captured overhead
// ****************************************
// only while aligned
assign e1_capture_ok = e1_mode_ff & in_frame_align;
assign si_slot = mf_frame_num[3:1];

always @*
begin
	nxt_bit_code = rx_bit_code_last_ff;
	nxt_align = rx_align_frame_bits_ff;
	nxt_nonalign = rx_nonalign_frame_bits_ff;
	nxt_si_even = rx_intl_bits_even_frames_ff;
	if (rx_bit_code_vld && !e1_mode_ff)
	begin
		nxt_bit_code = {2'b00, rx_bit_code_value};
	end
	if (e1_capture_ok && ts0_align_stb)
	begin
		nxt_align = ts0_byte;
		if (!mf_frame_num[0])
		begin
			nxt_si_even[si_slot] = ts0_byte[7];
		end
	end
	if (e1_capture_ok && ts0_nonalign_stb)
	begin
		nxt_nonalign = ts0_byte;
	end
end

always @(posedge clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		rx_bit_code_last_ff <= `RXOHS_RST_BYTE;
		rx_align_frame_bits_ff <= `RXOHS_RST_BYTE;
		rx_nonalign_frame_bits_ff <= `RXOHS_RST_BYTE;
		rx_intl_bits_even_frames_ff <= `RXOHS_RST_BYTE;
	end
	else
	begin
		rx_bit_code_last_ff <= nxt_bit_code;
		rx_align_frame_bits_ff <= nxt_align;
		rx_nonalign_frame_bits_ff <= nxt_nonalign;
		rx_intl_bits_even_frames_ff <= nxt_si_even;
	end
end

// ****************************************
// Control registers
// ****************************************
always @*
begin
	nxt_e1_mode = e1_mode_ff;
	nxt_d4_mode = d4_mode_ff;
	nxt_crc4_enable = crc4_enable_ff;
	if (reg_wr && hit(reg_addr, `RXOHS_OFF_MODE_CTRL))
	begin
		nxt_e1_mode = reg_wdata[`RXOHS_MODE_E1_BIT];
		nxt_d4_mode = reg_wdata[`RXOHS_MODE_D4_BIT];
	end
	if (reg_wr && hit(reg_addr, `RXOHS_OFF_RX_CTRL1))
	begin
		nxt_crc4_enable = reg_wdata[`RXOHS_CTRL1_CRC4_BIT];
	end
end

always @(posedge clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		e1_mode_ff <= MODE_RST[`RXOHS_MODE_E1_BIT];
		d4_mode_ff <= MODE_RST[`RXOHS_MODE_D4_BIT];
		crc4_enable_ff <= CTRL1_RST[`RXOHS_CTRL1_CRC4_BIT];
	end
	else
	begin
		e1_mode_ff <= nxt_e1_mode;
		d4_mode_ff <= nxt_d4_mode;
		crc4_enable_ff <= nxt_crc4_enable;
	end
end

assign mode_ctrl_view = {6'h00, d4_mode_ff, e1_mode_ff};
assign rx_ctrl1_view = {4'h0, crc4_enable_ff, 3'h0};

// ****************************************
// Read path
// ****************************************
// Data appear the cycle after the strobe; otherwise zero
always @*
begin
	nxt_rdata = 8'h00;
	if (reg_rd)
	begin
		case (reg_addr)
			`RXOHS_OFF_FW_REV:
			begin
				nxt_rdata = FW_REVISION;
			end
			`RXOHS_OFF_DL_STAT:
			begin
				nxt_rdata = mode_view(e1_mode_ff, rx_facility_link_bits, rx_realtime_sync_status);
			end
			`RXOHS_OFF_BIT_CODE:
			begin
				nxt_rdata = mode_view(e1_mode_ff, rx_bit_code_last_ff, 8'h00);
			end
			`RXOHS_OFF_OH_WORD1:
			begin
				nxt_rdata = mode_view(e1_mode_ff, carrier_word[7:0], rx_align_frame_bits_ff);
			end
			`RXOHS_OFF_OH_WORD2:
			begin
				nxt_rdata = mode_view(e1_mode_ff, carrier_word[15:8], rx_nonalign_frame_bits_ff);
			end
			`RXOHS_OFF_OH_WORD3:
			begin
				nxt_rdata = mode_view(e1_mode_ff, carrier_word[23:16], rx_intl_bits_even_frames_ff);
			end
			`RXOHS_OFF_MODE_CTRL:
			begin
				nxt_rdata = mode_ctrl_view;
			end
			`RXOHS_OFF_RX_CTRL1:
			begin
				nxt_rdata = rx_ctrl1_view;
			end
			default:
			begin
				nxt_rdata = 8'h00;
			end
		endcase
	end
end

always @(posedge clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		reg_rdata_ff <= `RXOHS_RST_BYTE;
	end
	else
	begin
		reg_rdata_ff <= nxt_rdata;
	end
end

endmodule // rxohs_regs

// *** rxohs_regs_asserts.sv ***
`timescale 1ns/1ps
// ****************************************
// Port-level checks of the register bank
// ****************************************
module rxohs_regs_asserts
#(
	parameter [7:0] FW_REVISION = 8'h01
)
(
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_ff,
	input wire e1_mode_ff,
	input wire crc4_enable_ff,
	// Framer side
	input wire crc4_mf_search_active,
	input wire cas_mf_search_active,
	input wire frame_align_search_active,
	input wire crc4_mf_sync_ok,
	input wire in_frame_align,
	input wire ts0_nonalign_stb,
	input wire [7:0] ts0_byte
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_clr;
		crc4_mf_sync_ok ##1 reg_rd && e1_mode_ff && reg_addr == 8'h62;
	endsequence
	sequence s_off;
		!crc4_enable_ff ##1 reg_rd && e1_mode_ff && reg_addr == 8'h62;
	endsequence
	sequence s_na;
		in_frame_align && e1_mode_ff && ts0_nonalign_stb ##1 reg_rd && e1_mode_ff && reg_addr == 8'h65;
	endsequence
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
		else $error("read data outside read slot");
	a_fw_fixed: assert property (reg_rd && reg_addr == 8'h61 |=> reg_rdata_ff == FW_REVISION)
		else $error("revision byte wrong");
	a_crc4_hunt: assert property (reg_rd && e1_mode_ff && reg_addr == 8'h62 |=> reg_rdata_ff[2] == $past(crc4_mf_search_active))
		else $error("crc4 hunt bit wrong");
	a_cas_hunt: assert property (reg_rd && e1_mode_ff && reg_addr == 8'h62 |=> reg_rdata_ff[1] == $past(cas_mf_search_active))
		else $error("cas hunt bit wrong");
	a_fas_hunt: assert property (reg_rd && e1_mode_ff && reg_addr == 8'h62 |=> reg_rdata_ff[0] == $past(frame_align_search_active))
		else $error("fas hunt bit wrong");
	a_code_top: assert property (reg_rd && !e1_mode_ff && reg_addr == 8'h63 |=> reg_rdata_ff[7:6] == 2'b00)
		else $error("code top bits set");
	a_crc4_ctrl: assert property (reg_wr && reg_addr == 8'h71 |=> ($past(reg_wdata) & 8'h08) == {4'h0, crc4_enable_ff, 3'h0})
		else $error("crc4 enable not written");
	a_cnt_sync: assert property (s_clr |=> reg_rdata_ff[7:3] == 5'h00)
		else $error("count not cleared by sync");
	a_cnt_off: assert property (s_off |=> reg_rdata_ff[7:3] == 5'h00)
		else $error("count not held clear while disabled");
	a_na_capture: assert property (s_na |=> reg_rdata_ff == $past(ts0_byte, 2))
		else $error("non-align byte not captured");
endmodule // rxohs_regs_asserts

bind rxohs_regs rxohs_regs_asserts #(.FW_REVISION(FW_REVISION)) u_chk (.clk(clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
	.e1_mode_ff(e1_mode_ff), .crc4_enable_ff(crc4_enable_ff), .crc4_mf_search_active(crc4_mf_search_active),
	.cas_mf_search_active(cas_mf_search_active), .frame_align_search_active(frame_align_search_active),
	.crc4_mf_sync_ok(crc4_mf_sync_ok), .in_frame_align(in_frame_align), .ts0_nonalign_stb(ts0_nonalign_stb),
	.ts0_byte(ts0_byte));

// *** rxohs_regs_tb_top.sv ***
`timescale 1ns/1ps
module rxohs_regs_tb_top;
	// Arbitrary revision value
	localparam [7:0] FW = 8'h5C;
	logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, hc = 0, hs = 0, hf = 0, expire = 0, sync_ok = 0;
	logic infa = 0, al_stb = 0, na_stb = 0, fl_bit = 0, fl_vld = 0, d4_bnd = 0, boc_vld = 0;
	logic c_bit = 0, c_vld = 0, c_bnd = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ts0_byte = 8'h00;
	logic [3:0] fnum = 4'h0;
	logic [5:0] boc = 6'h00;
	wire [7:0] rd_q;
	wire e1_q, d4_q, crc_q;
	int miscompares = 0;
	int checks = 0;
	rxohs_regs #(.FW_REVISION(FW)) u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rd_q), .e1_mode_ff(e1_q),
		.d4_mode_ff(d4_q), .crc4_enable_ff(crc_q), .crc4_mf_search_active(hc), .cas_mf_search_active(hs),
		.frame_align_search_active(hf), .crc4_search_expire(expire), .crc4_mf_sync_ok(sync_ok),
		.in_frame_align(infa), .ts0_align_stb(al_stb), .ts0_nonalign_stb(na_stb), .ts0_byte(ts0_byte),
		.mf_frame_num(fnum), .rx_facility_link_bit(fl_bit), .rx_facility_link_vld(fl_vld),
		.d4_mf_boundary(d4_bnd), .rx_bit_code_vld(boc_vld), .rx_bit_code_value(boc), .carrier_bit(c_bit),
		.carrier_bit_vld(c_vld), .carrier_sf_boundary(c_bnd));
	initial
	begin
		forever #2 clk = ~clk;
	end
	// ****************************************
	// Bus cycles and compares
	// ****************************************
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), e, rd_q);
	endtask
	task automatic ser(input bit car, input int n, input logic [23:0] v);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			fl_vld <= !car;
			c_vld <= car;
			fl_bit <= v[i];
			c_bit <= v[i];
		end
		@(posedge clk);
		fl_vld <= 1'b0;
		c_vld <= 1'b0;
	endtask
	task automatic stb(input bit na, input logic [3:0] f, input logic [7:0] b);
		@(posedge clk);
		al_stb <= !na;
		na_stb <= na;
		fnum <= f;
		ts0_byte <= b;
		@(posedge clk);
		al_stb <= 1'b0;
		na_stb <= 1'b0;
	endtask
	// Each expiry is a lone pulse, so back-to-back cases are not merged
	task automatic expire_n(input int n);
		repeat (n)
		begin
			@(posedge clk);
			expire <= 1'b1;
			@(posedge clk);
			expire <= 1'b0;
		end
	endtask
	function automatic logic [7:0] cv(input logic [5:0] c);
		return {c[5:2], c[0], 3'b000};
	endfunction
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rd(8'h61, FW);
		wr(8'h61, 8'hFF);
		rd(8'h61, FW);
		for (int a = 8'h62; a <= 8'h66; a++)
			rd(a[7:0], 8'h00);
		rd(8'h7F, 8'h00);
	endtask
	task automatic t_t1;
		@(posedge clk);
		boc_vld <= 1'b1;
		boc <= 6'h2A;
		@(posedge clk);
		boc_vld <= 1'b0;
		rd(8'h63, 8'h2A);
		ser(0, 8, 24'h0000B4);
		rd(8'h62, 8'hB4);
		wr(8'h70, 8'h02);
		#1;
		chk("mode pins", 8'h02, {6'h00, d4_q, e1_q});
		rd(8'h70, 8'h02);
		ser(0, 6, 24'h00002D);
		rd(8'h62, 8'hB4);
		@(posedge clk);
		d4_bnd <= 1'b1;
		@(posedge clk);
		d4_bnd <= 1'b0;
		rd(8'h62, 8'h2D);
		ser(1, 24, 24'h5A3C96);
		@(posedge clk);
		c_bnd <= 1'b1;
		@(posedge clk);
		c_bnd <= 1'b0;
		rd(8'h64, 8'h96);
		rd(8'h65, 8'h3C);
		rd(8'h66, 8'h5A);
	endtask
	task automatic t_status;
		wr(8'h70, 8'h01);
		#1;
		chk("mode pins", 8'h01, {6'h00, d4_q, e1_q});
		rd(8'h70, 8'h01);
		hc <= 1'b1;
		hf <= 1'b1;
		rd(8'h62, 8'h05);
		hc <= 1'b0;
		hs <= 1'b1;
		hf <= 1'b0;
		rd(8'h62, 8'h02);
		hs <= 1'b0;
		rd(8'h63, 8'h00);
	endtask
	task automatic t_count;
		wr(8'h71, 8'h08);
		#1;
		chk("crc4 pin", 8'h01, {7'h00, crc_q});
		rd(8'h71, 8'h08);
		expire_n(5);
		rd(8'h62, cv(6'd5));
		expire_n(58);
		rd(8'h62, cv(6'h3F));
		expire_n(2);
		rd(8'h62, cv(6'h3F));
		// Sync held across the read so the clear is seen at once
		sync_ok <= 1'b1;
		rd(8'h62, 8'h00);
		sync_ok <= 1'b0;
		expire_n(3);
		rd(8'h62, cv(6'd3));
		wr(8'h71, 8'h00);
		#1;
		chk("crc4 pin", 8'h00, {7'h00, crc_q});
		rd(8'h62, 8'h00);
		expire_n(2);
		rd(8'h62, 8'h00);
	endtask
	task automatic t_capture;
		infa <= 1'b1;
		for (int i = 0; i < 8; i++)
			stb(0, 4'(2 * i), {i[0], 7'h1B});
		rd(8'h64, 8'h9B);
		rd(8'h66, 8'hAA);
		// Strobe held across the read: capture, then readback next cycle
		na_stb <= 1'b1;
		ts0_byte <= 8'hE5;
		rd(8'h65, 8'hE5);
		na_stb <= 1'b0;
		infa <= 1'b0;
		stb(0, 4'h0, 8'h1B);
		stb(1, 4'h3, 8'h00);
		rd(8'h64, 8'h9B);
		rd(8'h65, 8'hE5);
		rd(8'h66, 8'hAA);
	endtask
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_t1();
		t_status();
		t_count();
		t_capture();
		give_verdict();
	end
	// Whole run is well under two thousand cycles
	initial
	begin
		#20000;
		miscompares++;
		give_verdict();
	end
endmodule // rxohs_regs_tb_top
